// File: pkg/cdp_pkg.sv
// clock divider and power mode controller: constants and types
package cdp_pkg;

  // timing: ref_clk is the multiplied clock, four times the external input
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          EXT_PERIOD_NS   = 80;
  localparam int          SWITCH_MAX_CYC  = EXT_PERIOD_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [3:0]  OFS_CLOCK_RATIO = 4'h0;
  localparam logic [3:0]  OFS_STANDBY     = 4'h4;
  localparam logic [3:0]  OFS_MODSTOP_A   = 4'h8;
  localparam logic [3:0]  OFS_STATUS      = 4'hc;

  // clock_ratio_control fields
  localparam int          SYS_LSB         = 8;
  localparam int          PER_LSB         = 4;
  localparam int          BUS_LSB         = 0;
  localparam logic [2:0]  RATIO_RST       = 3'h2;

  // standby control fields
  localparam int          SB_SW_STANDBY   = 0;
  localparam int          SB_ALL_STOP     = 1;

  // module_stop_control_a fields and reset value
  localparam int          TMR_STOP_LO     = 8;
  localparam int          TMR_STOP_HI     = 11;
  localparam int          DTC_STOP_BIT    = 6;
  localparam int          DMA_STOP_BIT    = 13;
  localparam logic [15:0] MODSTOP_RST     = 16'hdfbf;

  // half-period codes: 0 = 1/2, 1 = 1/4, 2 = 1/8 of ref_clk
  localparam logic [1:0]  HALF_DIV2       = 2'h0;
  localparam logic [1:0]  HALF_DIV4       = 2'h1;
  localparam logic [1:0]  HALF_DIV8       = 2'h2;

  typedef enum logic [2:0] {
    PM_NORMAL,
    PM_SLEEP,
    PM_ALL_STOP,
    PM_SW_STANDBY,
    PM_HW_STANDBY
  } cdp_pm_e;

  // one divided clock: level, cycle within phase, half-period code
  typedef struct packed {
    logic       lvl;
    logic [1:0] pc;
    logic [1:0] half;
  } cdp_clk_s;

  // wake sources, all one-cycle or level requests from on-chip logic
  typedef struct packed {
    logic ext;
    logic timer8;
    logic wdt;
    logic other;
  } cdp_wake_s;

  // three ratio codes as held in the control register
  typedef struct packed {
    logic [2:0] sys;
    logic [2:0] per;
    logic [2:0] bus;
  } cdp_ratio_s;

endpackage

// File: rtl/cdp_clock_power.sv
// clock divider and power mode controller, avalon-mm register slave
`timescale 1ns/1ps
module cdp_clock_power (
  // clock and reset
  input  wire  logic                   ref_clk,
  input  wire  logic                   rst_b,
  // avalon-mm slave
  input  wire  logic [3:0]             avs_address,
  input  wire  logic                   avs_read,
  input  wire  logic                   avs_write,
  input  wire  logic [31:0]            avs_writedata,
  input  wire  logic [3:0]             avs_byteenable,
  output logic       [31:0]            avs_readdata,
  output logic                         avs_waitrequest,
  // cpu and system status
  input  wire  logic                   sleep_exec,
  input  wire  logic                   ext_bus_busy,
  input  wire  cdp_pkg::cdp_wake_s     wake,
  input  wire  logic                   hw_standby_b,
  // divided clocks
  output logic                         sys_clk,
  output logic                         periph_clk,
  output logic                         extbus_clk,
  // power controls
  output logic                         cpu_halt,
  output logic                         osc_enable,
  output logic                         wdt_run,
  output logic                         timer8_run,
  output logic                         timer8_pin_oe,
  output logic                         serial_reset,
  output logic                         periph_reset,
  output logic                         io_hold,
  output logic                         io_hiz,
  output logic       [15:0]            module_stop
);
  import cdp_pkg::*;

  localparam int SW_MAX = SWITCH_MAX_CYC;

  function automatic logic [1:0] ratio_half(input logic [2:0] code);
    // the two slowest codes share the slowest available divider
    unique case (code[1:0])
      2'h0:    ratio_half = HALF_DIV2;
      2'h1:    ratio_half = HALF_DIV4;
      default: ratio_half = HALF_DIV8;
    endcase
  endfunction

  function automatic logic [1:0] phase_last(input logic [1:0] half);
    phase_last = 2'((3'h1 << half) - 3'h1);
  endfunction

  function automatic cdp_clk_s clk_step(input cdp_clk_s c, input logic [1:0] nh,
                                        input logic en);
    cdp_clk_s r;
    r = c;
    if (c.pc == phase_last(c.half)) begin
      // new ratio only at a phase end, so no phase is ever shortened
      r.pc   = 2'h0;
      r.half = nh;
      r.lvl  = c.lvl ? 1'b0 : en;
    end else begin
      r.pc = c.pc + 2'h1;
    end
    return r;
  endfunction

  // bus slave
  cdp_ratio_s  ratio_r;
  cdp_ratio_s  cmt_r;
  logic        pend_r;
  logic [1:0]  sb_ctrl_r;
  logic [15:0] modstop_r;
  cdp_pm_e     pm_r;
  cdp_pm_e     pm_nxt;
  logic        acc;
  logic        wr_go;
  logic [31:0] rd_val;

  assign acc   = avs_read | avs_write;
  assign wr_go = avs_write & ~avs_waitrequest;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(acc & avs_waitrequest);
    end
  end

  always_comb begin
    rd_val = 32'h0;
    unique case (avs_address)
      OFS_CLOCK_RATIO: begin
        rd_val[SYS_LSB +: 3] = ratio_r.sys;
        rd_val[PER_LSB +: 3] = ratio_r.per;
        rd_val[BUS_LSB +: 3] = ratio_r.bus;
      end
      OFS_STANDBY:   rd_val[1:0] = sb_ctrl_r;
      OFS_MODSTOP_A: rd_val[15:0] = modstop_r;
      OFS_STATUS:    rd_val[3:0] = {pend_r, pm_r};
      default:       rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_val;
    end
  end

  // ratio register: a prohibited code leaves its field unchanged
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ratio_r <= '{sys: RATIO_RST, per: RATIO_RST, bus: RATIO_RST};
    end else if (wr_go && avs_address == OFS_CLOCK_RATIO) begin
      if (avs_byteenable[1] && !avs_writedata[SYS_LSB+2]) begin
        ratio_r.sys <= avs_writedata[SYS_LSB +: 3];
      end
      if (avs_byteenable[0] && !avs_writedata[PER_LSB+2]) begin
        ratio_r.per <= avs_writedata[PER_LSB +: 3];
      end
      if (avs_byteenable[0] && !avs_writedata[BUS_LSB+2]) begin
        ratio_r.bus <= avs_writedata[BUS_LSB +: 3];
      end
    end
  end

  // pending change is held while the external bus cycle runs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
      cmt_r  <= '{sys: RATIO_RST, per: RATIO_RST, bus: RATIO_RST};
    end else if (wr_go && avs_address == OFS_CLOCK_RATIO) begin
      pend_r <= 1'b1;
    end else if (pend_r && !ext_bus_busy) begin
      pend_r <= 1'b0;
      cmt_r  <= ratio_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sb_ctrl_r <= 2'h0;
      modstop_r <= MODSTOP_RST;
    end else if (wr_go) begin
      if (avs_address == OFS_STANDBY && avs_byteenable[0]) begin
        sb_ctrl_r <= avs_writedata[1:0];
      end
      if (avs_address == OFS_MODSTOP_A) begin
        if (avs_byteenable[0]) begin
          modstop_r[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          modstop_r[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end

  // divided clocks
  logic [1:0] sys_h, per_h, bus_h;
  logic [1:0] sys_e, per_e, bus_e;
  cdp_clk_s   sys_c, per_c, bus_c;
  logic       apply;

  assign apply = pend_r & ~ext_bus_busy;
  assign sys_h = ratio_half(apply ? ratio_r.sys : cmt_r.sys);
  assign per_h = ratio_half(apply ? ratio_r.per : cmt_r.per);
  assign bus_h = ratio_half(apply ? ratio_r.bus : cmt_r.bus);
  assign sys_e = sys_h;
  assign per_e = (per_h < sys_h) ? sys_h : per_h;
  assign bus_e = (bus_h < sys_h) ? sys_h : bus_h;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_c <= '{lvl: 1'b0, pc: 2'h0, half: HALF_DIV8};
      per_c <= '{lvl: 1'b0, pc: 2'h0, half: HALF_DIV8};
      bus_c <= '{lvl: 1'b0, pc: 2'h0, half: HALF_DIV8};
    end else begin
      // cpu and transfer controller share sys clock; peripherals stop later
      sys_c <= clk_step(sys_c, sys_e, pm_r == PM_NORMAL);
      per_c <= clk_step(per_c, per_e, pm_r inside {PM_NORMAL, PM_SLEEP});
      bus_c <= clk_step(bus_c, bus_e, pm_r inside {PM_NORMAL, PM_SLEEP});
    end
  end

  assign sys_clk    = sys_c.lvl;
  assign periph_clk = per_c.lvl;
  assign extbus_clk = bus_c.lvl;

  // hardware standby pin synchroniser
  logic hw_s1_r, hw_s2_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hw_s1_r <= 1'b1;
      hw_s2_r <= 1'b1;
    end else begin
      hw_s1_r <= hw_standby_b;
      hw_s2_r <= hw_s1_r;
    end
  end

  // power mode sequencer
  always_comb begin
    pm_nxt = pm_r;
    unique case (pm_r)
      PM_NORMAL: begin
        if (sleep_exec) begin
          if (sb_ctrl_r[SB_SW_STANDBY]) begin
            pm_nxt = PM_SW_STANDBY;
          end else if (sb_ctrl_r[SB_ALL_STOP]) begin
            pm_nxt = PM_ALL_STOP;
          end else begin
            pm_nxt = PM_SLEEP;
          end
        end
      end
      PM_SLEEP: begin
        if (|wake) begin
          pm_nxt = PM_NORMAL;
        end
      end
      PM_ALL_STOP: begin
        if (wake.ext || wake.timer8 || wake.wdt) begin
          pm_nxt = PM_NORMAL;
        end
      end
      PM_SW_STANDBY: begin
        if (wake.ext) begin
          pm_nxt = PM_NORMAL;
        end
      end
      PM_HW_STANDBY: begin
        if (hw_s2_r) begin
          pm_nxt = PM_NORMAL;
        end
      end
    endcase
    if (!hw_s2_r) begin
      pm_nxt = PM_HW_STANDBY;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pm_r <= PM_NORMAL;
    end else begin
      pm_r <= pm_nxt;
    end
  end

  // mode outputs registered from the next state, aligned with pm_r
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_halt      <= 1'b0;
      osc_enable    <= 1'b1;
      wdt_run       <= 1'b1;
      timer8_run    <= 1'b0;
      timer8_pin_oe <= 1'b0;
      serial_reset  <= 1'b0;
      periph_reset  <= 1'b0;
      io_hold       <= 1'b0;
      io_hiz        <= 1'b0;
    end else begin
      cpu_halt      <= pm_nxt != PM_NORMAL;
      osc_enable    <= !(pm_nxt inside {PM_SW_STANDBY, PM_HW_STANDBY});
      wdt_run       <= pm_nxt inside {PM_NORMAL, PM_SLEEP, PM_ALL_STOP};
      timer8_run    <= (pm_nxt inside {PM_NORMAL, PM_SLEEP, PM_ALL_STOP}) &&
                       !(&modstop_r[TMR_STOP_HI:TMR_STOP_LO]);
      timer8_pin_oe <= (pm_nxt inside {PM_NORMAL, PM_SLEEP}) &&
                       !(&modstop_r[TMR_STOP_HI:TMR_STOP_LO]);
      serial_reset  <= pm_nxt inside {PM_ALL_STOP, PM_SW_STANDBY, PM_HW_STANDBY};
      periph_reset  <= pm_nxt == PM_HW_STANDBY;
      io_hold       <= pm_nxt inside {PM_ALL_STOP, PM_SW_STANDBY};
      io_hiz        <= pm_nxt == PM_HW_STANDBY;
    end
  end

  // halted modules keep register contents; only the reset lines clear them
  assign module_stop = modstop_r;

  // checks
  property p_half_legal;
    @(posedge ref_clk) disable iff (!rst_b)
      sys_c.half != 2'h3 && per_c.half != 2'h3 && bus_c.half != 2'h3;
  endproperty
  a_half_legal: assert property (p_half_legal) else $error("illegal divider");
  property p_clamp;
    @(posedge ref_clk) disable iff (!rst_b)
      per_e >= sys_e && bus_e >= sys_e;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clock faster than sys");
  property p_hold_busy;
    @(posedge ref_clk) disable iff (!rst_b)
      (pend_r && ext_bus_busy) |=> $stable(cmt_r);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("ratio changed in bus cycle");
  property p_switch_time;
    @(posedge ref_clk) disable iff (!rst_b)
      (apply && !(wr_go && avs_address == OFS_CLOCK_RATIO))
        |-> ##[1:SW_MAX] (sys_c.half == ratio_half(cmt_r.sys));
  endproperty
  a_switch_time: assert property (p_switch_time) else $error("switch too slow");
  property p_phase_len;
    @(posedge ref_clk) disable iff (!rst_b)
      $changed(sys_c.lvl) |-> $past(sys_c.pc) == phase_last($past(sys_c.half));
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("short clock phase");
  property p_entry;
    @(posedge ref_clk) disable iff (!rst_b)
      ($past(pm_r) == PM_NORMAL && pm_r inside {PM_SLEEP, PM_ALL_STOP, PM_SW_STANDBY})
        |-> $past(sleep_exec);
  endproperty
  a_entry: assert property (p_entry) else $error("mode entered without sleep");
  property p_sw_wake;
    @(posedge ref_clk) disable iff (!rst_b)
      (pm_r == PM_SW_STANDBY && !wake.ext && hw_s2_r) |=> pm_r == PM_SW_STANDBY;
  endproperty
  a_sw_wake: assert property (p_sw_wake) else $error("standby left without ext");
  property p_osc;
    @(posedge ref_clk) disable iff (!rst_b)
      osc_enable == !(pm_r inside {PM_SW_STANDBY, PM_HW_STANDBY});
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator state wrong");
  property p_serial;
    @(posedge ref_clk) disable iff (!rst_b)
      (pm_r inside {PM_ALL_STOP, PM_SW_STANDBY}) |-> serial_reset && io_hold && !periph_reset;
  endproperty
  a_serial: assert property (p_serial) else $error("stop mode outputs wrong");
  // outputs are registered from the next state, so they line up with pm_r
  property p_hw;
    @(posedge ref_clk) disable iff (!rst_b)
      !hw_s2_r |=> (pm_r == PM_HW_STANDBY && io_hiz && periph_reset && !wdt_run && cpu_halt);
  endproperty
  a_hw: assert property (p_hw) else $error("hardware standby outputs wrong");
  property p_timer_pin;
    @(posedge ref_clk) disable iff (!rst_b)
      pm_r == PM_ALL_STOP |-> !timer8_pin_oe;
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("timer pins on in stop");

endmodule // cdp_clock_power

// File: tb/cdp_far_model.sv
// far-side model: cpu sleep instruction and external bus cycles
`timescale 1ns/1ps
module cdp_far_model (
  // clock
  input  wire logic ref_clk,
  // to the block
  output logic      sleep_exec,
  output logic      ext_bus_busy
);
  initial begin
    sleep_exec   = 1'b0;
    ext_bus_busy = 1'b0;
  end
  // bus cycle held open as long as asked; ratio change must wait
  task automatic set_busy(input logic b);
    @(posedge ref_clk);
    ext_bus_busy <= b;
  endtask
  // sleep instruction, one clock wide; mode comes from control bits
  task automatic sleep_pulse();
    @(posedge ref_clk);
    sleep_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
  endtask
endmodule // cdp_far_model

// File: tb/clock_divider_power_modes_tb.sv
// self-checking bench for the clock divider and power mode controller
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, (e), (a)); end end
module clock_divider_power_modes_tb;
  import cdp_pkg::*;
  logic        ref_clk, rst_b, avs_read, avs_write, waitreq, sleep_exec, busy, hw_b;
  logic [3:0]  avs_address, avs_be;
  logic [31:0] avs_writedata, rdata, q;
  cdp_wake_s   wake;
  logic        sys_clk, periph_clk, extbus_clk, cpu_halt, osc_enable, wdt_run;
  logic        timer8_run, timer8_pin_oe, serial_reset, periph_reset, io_hold, io_hiz;
  logic [15:0] module_stop;
  int          n_errors, samples_checked, cyc, p;

  cdp_far_model far (.ref_clk(ref_clk), .sleep_exec(sleep_exec), .ext_bus_busy(busy));
  cdp_clock_power dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_be),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .sleep_exec(sleep_exec),
    .ext_bus_busy(busy), .wake(wake), .hw_standby_b(hw_b), .sys_clk(sys_clk),
    .periph_clk(periph_clk), .extbus_clk(extbus_clk), .cpu_halt(cpu_halt),
    .osc_enable(osc_enable), .wdt_run(wdt_run), .timer8_run(timer8_run),
    .timer8_pin_oe(timer8_pin_oe), .serial_reset(serial_reset),
    .periph_reset(periph_reset), .io_hold(io_hold), .io_hiz(io_hiz),
    .module_stop(module_stop));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task final_report;
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report;
    end
  end

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    // no cycle count assumed; only the hang guard ends a stuck wait
    do begin
      @(posedge ref_clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic chk_mode(input logic [2:0] m);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("mode", m, q[2:0]);
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? sys_clk : (s == 1) ? periph_clk : extbus_clk;
  endfunction

  // ref_clk cycles between two rising edges of a divided clock
  task automatic period(input int s, output int n);
    logic pv, c;
    int   st;
    st = 0;
    n  = 0;
    pv = pick(s);
    for (int i = 0; i < 60 && st < 2; i++) begin
      @(posedge ref_clk);
      c = pick(s);
      if (st == 1) n++;
      if (c === 1'b1 && pv === 1'b0) st++;
      pv = c;
    end
  endtask

  task automatic wake_pulse(input cdp_wake_s w);
    @(posedge ref_clk);
    wake <= w;
    @(posedge ref_clk);
    wake <= '0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t_reset;
    `CHK("module_stop", 16'hdfbf, module_stop);
    `CHK("timer8_run", 1'b0, timer8_run);
    `CHK("osc_enable", 1'b1, osc_enable);
    bus(1'b0, OFS_CLOCK_RATIO, 32'h0);
    `CHK("ratio", 32'h222, q);
    bus(1'b0, 4'h1, 32'h0);
    `CHK("unmapped", 32'h0, q);
    period(0, p);
    `CHK("sys_period", 8, p);
  endtask

  // legal ratios, the shared code 3, and a prohibited bus code 4 that must be ignored
  task automatic t_ratio;
    far.set_busy(1'b1);
    bus(1'b1, OFS_CLOCK_RATIO, 32'h001);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("pending", 1'b1, q[3]);
    period(0, p);
    `CHK("sys_held", 8, p);
    far.set_busy(1'b0);
    repeat (6) @(posedge ref_clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("pending_clr", 1'b0, q[3]);
    period(0, p);
    `CHK("sys_div2", 2, p);
    period(1, p);
    `CHK("per_div2", 2, p);
    period(2, p);
    `CHK("bus_div4", 4, p);
    bus(1'b1, OFS_CLOCK_RATIO, 32'h004);
    bus(1'b0, OFS_CLOCK_RATIO, 32'h0);
    `CHK("bad_code", 32'h001, q);
    bus(1'b1, OFS_CLOCK_RATIO, 32'h100);
    repeat (8) @(posedge ref_clk);
    period(1, p);
    `CHK("per_clamp", 4, p);
    period(2, p);
    `CHK("bus_clamp", 4, p);
    bus(1'b1, OFS_CLOCK_RATIO, 32'h333);
    repeat (12) @(posedge ref_clk);
    period(0, p);
    `CHK("sys_code3", 8, p);
  endtask

  task automatic t_modes;
    bus(1'b1, OFS_STANDBY, 32'h0);
    far.sleep_pulse();
    chk_mode(3'h1);
    `CHK("halt_sleep", 1'b1, cpu_halt);
    `CHK("osc_sleep", 1'b1, osc_enable);
    period(1, p);
    `CHK("per_sleep", 8, p);
    wake_pulse(4'b0001);
    chk_mode(3'h0);
    bus(1'b1, OFS_MODSTOP_A, 32'hd0bf);
    // the write lands on the edge the task returns at; look one edge later
    @(posedge ref_clk);
    `CHK("modstop", 16'hd0bf, module_stop);
    bus(1'b1, OFS_STANDBY, 32'h2);
    far.sleep_pulse();
    chk_mode(3'h2);
    `CHK("ser_rst", 1'b1, serial_reset);
    `CHK("io_hold", 1'b1, io_hold);
    `CHK("t8_run", 1'b1, timer8_run);
    `CHK("t8_oe", 1'b0, timer8_pin_oe);
    `CHK("osc_stop", 1'b1, osc_enable);
    wake_pulse(4'b0001);
    chk_mode(3'h2);
    wake_pulse(4'b0100);
    chk_mode(3'h0);
    `CHK("t8_oe_norm", 1'b1, timer8_pin_oe);
    bus(1'b1, OFS_STANDBY, 32'h1);
    far.sleep_pulse();
    chk_mode(3'h3);
    `CHK("osc_sby", 1'b0, osc_enable);
    `CHK("ser_sby", 1'b1, serial_reset);
    wake_pulse(4'b0100);
    chk_mode(3'h3);
    wake_pulse(4'b1000);
    chk_mode(3'h0);
  endtask

  task automatic t_hw;
    @(posedge ref_clk);
    hw_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk_mode(3'h4);
    `CHK("io_hiz", 1'b1, io_hiz);
    `CHK("per_rst", 1'b1, periph_reset);
    `CHK("wdt_off", 1'b0, wdt_run);
    `CHK("cpu_hw", 1'b1, cpu_halt);
    hw_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_mode(3'h0);
  endtask

  initial begin
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_be = 4'hf;
    wake = '0;
    hw_b = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_reset;
    t_ratio;
    t_modes;
    t_hw;
    final_report;
  end
endmodule // clock_divider_power_modes_tb
